// file: pin_counter_model.sv
// model of the shared counter and the external channel pins
`timescale 1ns/1ps
`default_nettype none
module pin_counter_model #(
	parameter logic [15:0] TOP = 16'h00ff
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        halt,
	input  wire logic [1:0]  pin_req,
	output var  logic [15:0] cnt_ff,
	output var  logic        ovf_ff,
	output var  logic [1:0]  pin_ff
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 16'h0000;
			ovf_ff <= 1'b0;
			pin_ff <= 2'b00;
		end else begin
			pin_ff <= pin_req;
			ovf_ff <= !halt && cnt_ff == TOP;
			if (!halt)
				cnt_ff <= (cnt_ff == TOP) ? 16'h0000 : cnt_ff + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// register-level test of the timer channels
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, halt, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lo1;
	logic        pready, pslverr, ovf;
	logic [1:0]  pin_req, pin, out, oe, irq;
	logic [15:0] cnt;
	int          error_cnt, samples_checked;
	tmr_chan dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.counter_value(cnt), .counter_overflow(ovf),
		.counter_halt_bit(halt), .channel_pin_in(pin),
		.channel_pin_out_ff(out), .channel_pin_oe_ff(oe),
		.channel_irq_ff(irq));
	pin_counter_model far (.pclk(pclk), .presetn(presetn), .halt(halt),
		.pin_req(pin_req), .cnt_ff(cnt), .ovf_ff(ovf), .pin_ff(pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] r);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			report_and_stop;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// bounded wait on irq of channel 0 or output of channel 1
	task automatic wait_bit(input logic sel, input logic exp);
		int n;
		for (n = 0; n < 600 && (sel ? out[1] : irq[0]) !== exp; n++)
			@(posedge pclk);
		if (n == 600) begin
			error_cnt++;
			report_and_stop;
		end
	endtask
	initial begin
		{presetn, psel, penable, pwrite, halt} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pin_req = 2'b00;
		error_cnt = 0;
		samples_checked = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h114, 8'h00, rd);
		chk("ctrl0 reset", 32'h0000_0000, rd);
		apb(0, 12'h004, 8'h00, rd);
		chk("unmapped err", 1, e);
		$display("test registers done");
		apb(1, 12'h120, 8'h10, rd);
		chk("preset oe", 0, oe[1]);
		for (int c = 3; c >= 2; c--) begin
			halt <= 1'b1;
			apb(1, 12'h124, 8'h00, rd);
			apb(1, 12'h128, 8'h40, rd);
			apb(1, 12'h120, 8'(8'h10 | (c << 2)), rd);
			halt <= 1'b0;
			wait_bit(1, c == 3);
			chk("cmp out", c == 3, out[1]);
			chk("cmp oe", 1, oe[1]);
		end
		$display("test compare done");
		apb(1, 12'h114, 8'h44, rd);
		pin_req[0] <= 1'b1;
		wait_bit(0, 1);
		apb(0, 12'h114, 8'h00, rd);
		chk("cap flag", 32'h0000_00c4, rd);
		apb(0, 12'h118, 8'h00, rd);
		apb(0, 12'h11c, 8'h00, lo1);
		apb(0, 12'h118, 8'h00, rd);
		pin_req[0] <= 1'b0;
		repeat (9) @(posedge pclk);
		pin_req[0] <= 1'b1;
		repeat (9) @(posedge pclk);
		apb(0, 12'h11c, 8'h00, rd);
		chk("blocked cap", lo1, rd);
		pin_req[0] <= 1'b0;
		repeat (9) @(posedge pclk);
		apb(0, 12'h11c, 8'h00, rd);
		chk("falling ignored", lo1, rd);
		pin_req[0] <= 1'b1;
		repeat (9) @(posedge pclk);
		apb(0, 12'h11c, 8'h00, rd);
		chk("new cap", 1, rd !== lo1);
		// flag clears only after a read that saw it set
		apb(0, 12'h114, 8'h00, rd);
		apb(1, 12'h114, 8'h04, rd);
		apb(0, 12'h114, 8'h00, rd);
		chk("flag clear", 32'h0000_0004, rd);
		chk("irq off", 0, irq[0]);
		$display("test capture done");
		report_and_stop;
	end
endmodule
`default_nettype wire

// file: tmr_chan.v
// two channels of a 16-bit timer: capture, compare, pwm, apb register slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_chan_defines.vh"

module tmr_chan #(
	parameter CW = 16
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg           pready,
	output reg  [31:0]   prdata,
	output reg           pslverr,
	input  wire [CW-1:0] counter_value,
	input  wire          counter_overflow,
	input  wire          counter_halt_bit,
	input  wire [1:0]    channel_pin_in,
	output reg  [1:0]    channel_pin_out_ff,
	output reg  [1:0]    channel_pin_oe_ff,
	output reg  [1:0]    channel_irq_ff
);

	// control registers, one per channel
	reg  [7:0]    ctrl_ff [0:1];
	reg  [CW-1:0] value_ff [0:1];
	reg  [1:0]    outst_ff;
	reg  [1:0]    cap_block_ff;
	reg  [1:0]    cmp_block_ff;
	reg  [1:0]    flag_armed_ff;
	reg  [1:0]    max_act_ff;
	reg  [2:0]    pin_sync_ff [0:1];
	reg  [1:0]    pin_prev_ff;
	reg           buf_sel_ff;
	reg           buf_pend_ff;

	wire          setup   = psel & ~penable;
	wire          access  = psel & penable;
	wire [9:0]    idx     = paddr[11:2];
	wire          aligned = (paddr[1:0] == 2'b00);
	wire          wr      = access & pwrite & aligned;
	wire          rd      = access & ~pwrite & aligned;
	wire          buffered = ctrl_ff[0][`F_MODE_B];

	// decode the word index into a register select
	reg  [2:0]    sel;
	reg           hit;
	always @* begin
		hit = 1'b1;
		sel = 3'd0;
		case (idx)
			{2'b00, `IDX_CTRL0}:  sel = 3'd0;
			{2'b00, `IDX_CH0_HI}: sel = 3'd1;
			{2'b00, `IDX_CH0_LO}: sel = 3'd2;
			{2'b00, `IDX_CTRL1}:  sel = 3'd3;
			{2'b00, `IDX_CH1_HI}: sel = 3'd4;
			{2'b00, `IDX_CH1_LO}: sel = 3'd5;
			default: hit = 1'b0;
		endcase
	end

	// apb: zero wait states, pready answers in the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~(hit & (paddr[1:0] == 2'b00));
			prdata  <= 32'h0000_0000;
			if (setup && hit) begin
				case (sel)
					3'd0: prdata <= {24'h00_0000, ctrl_ff[0]};
					3'd1: prdata <= {24'h00_0000, value_ff[0][15:8]};
					3'd2: prdata <= {24'h00_0000, value_ff[0][7:0]};
					3'd3: prdata <= {24'h00_0000, ctrl_ff[1] & 8'hdf};
					3'd4: prdata <= {24'h00_0000, value_ff[1][15:8]};
					3'd5: prdata <= {24'h00_0000, value_ff[1][7:0]};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// access is taken in the cycle pready is high
	wire do_wr = wr & pready & hit;
	wire do_rd = rd & pready & hit;

	// buffered pair switch happens at overflow
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_sel_ff  <= 1'b0;
			buf_pend_ff <= 1'b0;
		end else if (!buffered) begin
			buf_sel_ff  <= 1'b0;
			buf_pend_ff <= 1'b0;
		end else begin
			if (do_wr && (sel == 3'd2 || sel == 3'd5))
				buf_pend_ff <= (sel == 3'd5);
			if (counter_overflow)
				buf_sel_ff <= buf_pend_ff;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ch
			localparam [2:0] SC = (g == 0) ? 3'd0 : 3'd3;
			localparam [2:0] SH = (g == 0) ? 3'd1 : 3'd4;
			localparam [2:0] SL = (g == 0) ? 3'd2 : 3'd5;
			// channel 1 is disabled while channel 0 runs buffered
			wire       dis  = (g == 1) & buffered;
			wire [7:0] c    = ctrl_ff[g];
			wire [1:0] els  = {c[`F_ELS_HI], c[`F_ELS_LO]};
			wire       modb = (g == 0) ? c[`F_MODE_B] : 1'b0;
			wire       on   = (els != `ELS_OFF) & ~dis;
			wire       cap  = on & ~modb & ~c[`F_MODE_A];
			wire       cmpm = on & (modb | c[`F_MODE_A]);
			wire       p1   = pin_sync_ff[g][1];
			wire       p2   = pin_sync_ff[g][2];
			wire       stbl = (p1 == p2);
			wire       rise = stbl & p2 & ~pin_prev_ff[g] & els[0];
			wire       fall = stbl & ~p2 & pin_prev_ff[g] & els[1];
			wire       edg  = cap & (rise | fall);
			// buffered compare uses the selected pair of the two
			wire [CW-1:0] cmpv = (g == 0 && buffered) ?
			                     value_ff[buf_sel_ff] : value_ff[g];
			wire       match = cmpm & ~cmp_block_ff[g] &
			                   (counter_value == cmpv);
			wire       tov  = c[`F_TOV] & cmpm;
			wire       cw   = do_wr & (sel == SC) & ~dis;
			wire       clr_flag = cw & ~pwdata[`F_FLAG] & flag_armed_ff[g];
			wire       take = edg & ~cap_block_ff[g] & ~counter_halt_bit;
			wire       evt  = take | match;

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_sync_ff[g] <= 3'b000;
					pin_prev_ff[g] <= 1'b0;
				end else begin
					pin_sync_ff[g] <= {pin_sync_ff[g][1:0],
					                   channel_pin_in[g]};
					if (stbl)
						pin_prev_ff[g] <= p2;
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_ff[g]       <= `CTRL_RESET;
					flag_armed_ff[g] <= 1'b0;
					cap_block_ff[g]  <= 1'b0;
					cmp_block_ff[g]  <= 1'b0;
				end else begin
					if (do_rd && sel == SC && c[`F_FLAG])
						flag_armed_ff[g] <= 1'b1;
					else if (cw)
						flag_armed_ff[g] <= 1'b0;
					if (cw)
						ctrl_ff[g][6:0] <= (g == 0) ? pwdata[6:0] :
						                   (pwdata[6:0] & 7'h5f);
					if (evt)
						ctrl_ff[g][`F_FLAG] <= 1'b1;
					else if (clr_flag)
						ctrl_ff[g][`F_FLAG] <= 1'b0;
					if (do_rd && sel == SH && cap)
						cap_block_ff[g] <= 1'b1;
					else if (do_rd && sel == SL)
						cap_block_ff[g] <= 1'b0;
					if (do_wr && sel == SH && cmpm)
						cmp_block_ff[g] <= 1'b1;
					else if (do_wr && sel == SL)
						cmp_block_ff[g] <= 1'b0;
				end
			end

			always @(posedge pclk) begin
				if (take)
					value_ff[g] <= counter_value;
				else if (do_wr && sel == SH)
					value_ff[g][15:8] <= pwdata[7:0];
				else if (do_wr && sel == SL)
					value_ff[g][7:0] <= pwdata[7:0];
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					outst_ff[g]           <= 1'b1;
					max_act_ff[g]         <= 1'b0;
					channel_pin_out_ff[g] <= 1'b0;
					channel_pin_oe_ff[g]  <= 1'b0;
					channel_irq_ff[g]     <= 1'b0;
				end else begin
					// max duty sampled at period start
					if (counter_overflow)
						max_act_ff[g] <= c[`F_MAX] & ~c[`F_TOV];
					if (!on) begin
						// preset level from mode bit a
						outst_ff[g] <= ~c[`F_MODE_A];
					end else if (cmpm) begin
						if (max_act_ff[g])
							outst_ff[g] <= 1'b1;
						else if (tov && counter_overflow)
							outst_ff[g] <= ~outst_ff[g];
						else if (match) begin
							case (els)
								`ELS_TOGGLE: outst_ff[g] <= ~outst_ff[g];
								`ELS_CLEAR:  outst_ff[g] <= 1'b0;
								`ELS_SET:    outst_ff[g] <= 1'b1;
								default:     outst_ff[g] <= outst_ff[g];
							endcase
						end
					end
					// pin released when field is 00
					channel_pin_oe_ff[g]  <= cmpm;
					channel_pin_out_ff[g] <= outst_ff[g];
					channel_irq_ff[g]     <= c[`F_FLAG] & c[`F_IRQ_EN];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// file: tmr_chan_assertions.sv
// bus and pin checker for the timer channels
`timescale 1ns/1ps
`default_nettype none
module tmr_chan_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [1:0]  channel_pin_oe_ff
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_needs_setup: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_unmapped: assert property (s_setup ##0 paddr == 12'h004 |=> pslverr)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (s_setup ##0 paddr == 12'h118 |=> !pslverr)
		else $error("mapped access refused");
	a_rdata_narrow: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	// pin ownership moves only on a register write
	a_oe_by_write: assert property ($changed(channel_pin_oe_ff) |->
		$past(penable && pwrite) || $past(penable && pwrite, 2))
		else $error("pin enable moved without write");
endmodule
bind tmr_chan tmr_chan_checker chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.channel_pin_oe_ff(channel_pin_oe_ff));
`default_nettype wire

// file: tmr_chan_defines.vh
// register map, field positions and timing constants of the timer channels
`ifndef TMR_CHAN_DEFINES_VH
`define TMR_CHAN_DEFINES_VH

// printed offsets are register indices; byte address is four times the index
`define IDX_CTRL0        8'h45
`define IDX_CH0_HI       8'h46
`define IDX_CH0_LO       8'h47
`define IDX_CTRL1        8'h48
`define IDX_CH1_HI       8'h49
`define IDX_CH1_LO       8'h4a

// control register fields
`define F_FLAG           7
`define F_IRQ_EN         6
`define F_MODE_B         5
`define F_MODE_A         4
`define F_ELS_HI         3
`define F_ELS_LO         2
`define F_TOV            1
`define F_MAX            0

`define CTRL_RESET       8'h00

// edge/level field codes
`define ELS_OFF          2'b00
`define ELS_TOGGLE       2'b01
`define ELS_CLEAR        2'b10
`define ELS_SET          2'b11

// pin must be stable before capture is enabled
`define PIN_STABLE_NS    20
`define CLK_PERIOD_NS    10
`define PIN_STABLE_CYC   ((`PIN_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
